// ==== verilog/page_access_pkg.sv ====
// constants shared by the test-port page access logic
// assumes a 4-bit instruction register and LSB-first shifting on every chain
`default_nettype none
package page_access_pkg;
  // instruction codes (arbitrary, not standard)
  localparam logic [3:0] IR_RST = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] CORE_RESET_INSTRUCTION = 4'hc;
  localparam logic [3:0] PROGRAMMING_ENABLE_INSTRUCTION = 4'h4;
  localparam logic [3:0] PROGRAMMING_COMMAND_INSTRUCTION = 4'h5;
  localparam logic [3:0] PAGE_LOAD_INSTRUCTION = 4'h6;
  localparam logic [3:0] PAGE_READ_INSTRUCTION = 4'h7;
  // programming enable key and command encodings
  localparam logic [15:0] PROG_KEY = 16'ha370;
  localparam logic [6:0] OP_MODE = 7'h23;
  localparam logic [6:0] OP_ADDR_HIGH = 7'h07;
  localparam logic [6:0] OP_ADDR_LOW = 7'h03;
  localparam logic [7:0] MODE_NOOP = 8'h00;
  localparam int MODE_EEPROM_BIT = 0;
  localparam int CMD_OP_LSB = 8;
  // reset values, read fill byte and last bit index of a byte
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;
endpackage
`default_nettype wire

// ==== verilog/byte_fifo.sv ====
// synchronous fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire push = wr_valid_in && !full;
  wire pop = rd_ready_in && !empty;
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem[rp_q[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= wr_data_in;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/page_access_port.sv ====
// test-port programming access: tap, enable/reset registers, page load and page read chains
// assumes TCK_IN is the programmer's clock; page buffer and flash read ports live on CLK_IN
`default_nettype none
module page_access_port import page_access_pkg::*; #(
  parameter int PAGE_BYTES = 128,
  parameter int PROGRAM_COUNTER_TOP_BIT = 13,
  parameter int EEPROM_ADDRESS_TOP_BIT = 9,
  parameter int FIFO_DEPTH = 32
) (
  // system
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // test port
  input wire logic TCK_IN,
  input wire logic TMS_IN,
  input wire logic TDI_IN,
  output logic TDO_OUT,
  output logic TDO_OE_OUT,
  // core control
  output logic CORE_RESET_OUT,
  output logic PROG_MODE_OUT,
  // flash page buffer write
  output logic PAGE_WR_VALID_OUT,
  output logic [16:0] PAGE_WR_ADDR_OUT,
  output logic [7:0] PAGE_WR_DATA_OUT,
  input wire logic PAGE_WR_READY_IN,
  // flash read
  output logic FLASH_RD_REQ_OUT,
  output logic [16:0] FLASH_RD_ADDR_OUT,
  input wire logic [7:0] FLASH_RD_DATA_IN,
  input wire logic FLASH_RD_VALID_IN
);
  localparam int IW = $clog2(PAGE_BYTES) + 1;
  localparam logic [IW-1:0] PB = IW'(PAGE_BYTES);
  localparam logic [15:0] PC_MASK = 16'((32'h1 << (PROGRAM_COUNTER_TOP_BIT + 1)) - 1);
  localparam logic [15:0] EE_MASK = 16'((32'h1 << (EEPROM_ADDRESS_TOP_BIT + 1)) - 1);
  localparam int FW = 25;

  // ********************************
  // tap controller (tck domain)
  // ********************************
  tap_state_t tap_q, tap_d;
  always_comb begin
    tap_d = tap_q;
    case (tap_q)
      TLR: tap_d = TMS_IN ? TLR : RTI;
      RTI: tap_d = TMS_IN ? SEL_DR : RTI;
      SEL_DR: tap_d = TMS_IN ? SEL_IR : CAP_DR;
      CAP_DR: tap_d = TMS_IN ? EX1_DR : SH_DR;
      SH_DR: tap_d = TMS_IN ? EX1_DR : SH_DR;
      EX1_DR: tap_d = TMS_IN ? UPD_DR : PA_DR;
      PA_DR: tap_d = TMS_IN ? EX2_DR : PA_DR;
      EX2_DR: tap_d = TMS_IN ? UPD_DR : SH_DR;
      UPD_DR: tap_d = TMS_IN ? SEL_DR : RTI;
      SEL_IR: tap_d = TMS_IN ? TLR : CAP_IR;
      CAP_IR: tap_d = TMS_IN ? EX1_IR : SH_IR;
      SH_IR: tap_d = TMS_IN ? EX1_IR : SH_IR;
      EX1_IR: tap_d = TMS_IN ? UPD_IR : PA_IR;
      PA_IR: tap_d = TMS_IN ? EX2_IR : PA_IR;
      EX2_IR: tap_d = TMS_IN ? UPD_IR : SH_IR;
      UPD_IR: tap_d = TMS_IN ? SEL_DR : RTI;
      default: tap_d = TLR;
    endcase
  end
  always_ff @(posedge TCK_IN or posedge RST_IN) begin
    if (RST_IN) tap_q <= TLR;
    else tap_q <= tap_d;
  end

  wire cap_dr = (tap_q == CAP_DR);
  wire sh_dr = (tap_q == SH_DR);
  wire upd_dr = (tap_q == UPD_DR);
  wire sh_ir = (tap_q == SH_IR);

  // ********************************
  // instruction register
  // ********************************
  logic [3:0] ir_sr_q, ir_q;
  always_ff @(posedge TCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ir_sr_q <= IR_CAPTURE;
      ir_q <= IR_RST;
    end else begin
      if (tap_q == CAP_IR) ir_sr_q <= IR_CAPTURE;
      else if (sh_ir) ir_sr_q <= {TDI_IN, ir_sr_q[3:1]};
      if (tap_q == TLR) ir_q <= IR_RST;
      else if (tap_q == UPD_IR) ir_q <= ir_sr_q;
    end
  end
  wire sel_rst = (ir_q == CORE_RESET_INSTRUCTION);
  wire sel_pe = (ir_q == PROGRAMMING_ENABLE_INSTRUCTION);
  wire sel_cmd = (ir_q == PROGRAMMING_COMMAND_INSTRUCTION);
  wire sel_ld = (ir_q == PAGE_LOAD_INSTRUCTION);
  wire sel_rd = (ir_q == PAGE_READ_INSTRUCTION);

  // ********************************
  // reset, enable and command registers
  // ********************************
  logic byp_q, rst_sr_q, core_rst_q, pe_ok_q;
  logic [15:0] pe_sr_q;
  logic [14:0] cmd_sr_q;
  logic [7:0] mode_q;
  logic [15:0] addr_q;
  wire [6:0] cmd_op = cmd_sr_q[14:CMD_OP_LSB];
  wire [7:0] cmd_arg = cmd_sr_q[7:0];
  wire [15:0] addr_mask = mode_q[MODE_EEPROM_BIT] ? EE_MASK : PC_MASK;
  wire [15:0] addr_hi = {cmd_arg, addr_q[7:0]} & addr_mask;
  wire [15:0] addr_lo = {addr_q[15:8], cmd_arg} & addr_mask;
  wire cmd_upd = upd_dr && sel_cmd && pe_ok_q;

  always_ff @(posedge TCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      byp_q <= 1'b0;
      rst_sr_q <= 1'b0;
      core_rst_q <= 1'b0;
      pe_sr_q <= '0;
      pe_ok_q <= 1'b0;
      cmd_sr_q <= '0;
    end else begin
      if (sh_dr) byp_q <= TDI_IN;
      if (sh_dr && sel_rst) rst_sr_q <= TDI_IN;
      if (upd_dr && sel_rst) core_rst_q <= rst_sr_q;
      if (sh_dr && sel_pe) pe_sr_q <= {TDI_IN, pe_sr_q[15:1]};
      // only the exact key keeps the mode; a zero pattern drops it
      if (upd_dr && sel_pe) pe_ok_q <= (pe_sr_q == PROG_KEY);
      if (sh_dr && sel_cmd) cmd_sr_q <= {TDI_IN, cmd_sr_q[14:1]};
    end
  end

  always_ff @(posedge TCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode_q <= MODE_RST;
      addr_q <= ADDR_RST;
    end else if (!pe_ok_q) begin
      mode_q <= MODE_NOOP;
    end else if (cmd_upd) begin
      if (cmd_op == OP_MODE) mode_q <= cmd_arg;
      if (cmd_op == OP_ADDR_HIGH) addr_q <= addr_hi;
      if (cmd_op == OP_ADDR_LOW) addr_q <= addr_lo;
    end
  end

  // ********************************
  // page load / page read chains
  // ********************************
  logic [7:0] pg_sr_q, ld_byte_q;
  logic [2:0] bit_q;
  logic [IW-1:0] byte_q, ld_idx_q, rd_idx_q;
  logic ld_tgl_q, rd_tgl_q, ack_s1_q, ack_s2_q, ack_tgl_q;
  logic [7:0] rd_data_q;
  wire ld_on = sel_ld && pe_ok_q;
  wire rd_on = sel_rd && pe_ok_q;
  wire [7:0] ld_next = {TDI_IN, pg_sr_q[7:1]};
  wire byte_end = (bit_q == LAST_BIT);
  wire rd_done = (ack_s2_q == rd_tgl_q);
  wire [7:0] rd_fill = (rd_done && byte_q < PB) ? rd_data_q : FILL_BYTE;
  wire [IW-1:0] byte_nx = byte_q + 1'b1;

  always_ff @(posedge TCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  always_ff @(posedge TCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pg_sr_q <= '0;
      bit_q <= '0;
      byte_q <= '0;
      ld_byte_q <= '0;
      ld_idx_q <= '0;
      ld_tgl_q <= 1'b0;
      rd_idx_q <= '0;
      rd_tgl_q <= 1'b0;
    end else if (cap_dr && (ld_on || rd_on)) begin
      bit_q <= '0;
      byte_q <= '0;
      if (rd_on) begin
        rd_idx_q <= '0;
        rd_tgl_q <= ~rd_tgl_q;
      end
    end else if (sh_dr && ld_on) begin
      pg_sr_q <= ld_next;
      bit_q <= bit_q + 1'b1;
      if (byte_end && byte_q < PB) begin
        ld_byte_q <= ld_next;
        ld_idx_q <= byte_q;
        ld_tgl_q <= ~ld_tgl_q;
        byte_q <= byte_nx;
      end
    end else if (sh_dr && rd_on) begin
      bit_q <= bit_q + 1'b1;
      if (byte_end) begin
        // beyond page plus eight bits the chain only returns fill
        pg_sr_q <= rd_fill;
        if (byte_q < PB) byte_q <= byte_nx;
        if (byte_nx < PB) begin
          rd_idx_q <= byte_nx;
          rd_tgl_q <= ~rd_tgl_q;
        end
      end else begin
        pg_sr_q <= {1'b0, pg_sr_q[7:1]};
      end
    end
  end

  // ********************************
  // tdo, launched on the falling edge
  // ********************************
  logic tdo_d;
  always_comb begin
    tdo_d = byp_q;
    if (sh_ir) tdo_d = ir_sr_q[0];
    else if (sel_rst) tdo_d = rst_sr_q;
    else if (sel_pe) tdo_d = pe_sr_q[0];
    else if (sel_cmd) tdo_d = cmd_sr_q[0];
    else if (sel_ld || sel_rd) tdo_d = pg_sr_q[0];
  end
  always_ff @(negedge TCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      TDO_OUT <= 1'b0;
      TDO_OE_OUT <= 1'b0;
    end else begin
      TDO_OUT <= tdo_d;
      TDO_OE_OUT <= sh_dr || sh_ir;
    end
  end

  // ********************************
  // system clock side: level and toggle synchronisers
  // ********************************
  logic rst_s1_q, pe_s1_q;
  logic ld_s1_q, ld_s2_q, ld_s3_q, rd_s1_q, rd_s2_q, rd_s3_q;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rst_s1_q <= 1'b0;
      CORE_RESET_OUT <= 1'b0;
      pe_s1_q <= 1'b0;
      PROG_MODE_OUT <= 1'b0;
      {ld_s1_q, ld_s2_q, ld_s3_q} <= 3'h0;
      {rd_s1_q, rd_s2_q, rd_s3_q} <= 3'h0;
    end else begin
      rst_s1_q <= core_rst_q;
      CORE_RESET_OUT <= rst_s1_q;
      pe_s1_q <= pe_ok_q;
      PROG_MODE_OUT <= pe_s1_q;
      {ld_s1_q, ld_s2_q, ld_s3_q} <= {ld_tgl_q, ld_s1_q, ld_s2_q};
      {rd_s1_q, rd_s2_q, rd_s3_q} <= {rd_tgl_q, rd_s1_q, rd_s2_q};
    end
  end
  wire ld_ev = ld_s2_q ^ ld_s3_q;
  wire rd_ev = rd_s2_q ^ rd_s3_q;
  // address word is static while a page transfer runs, so the event qualifies it
  wire [16:0] page_base = {addr_q, 1'b0};

  // ********************************
  // page load path into the fifo
  // ********************************
  logic hold_q;
  logic [FW-1:0] hold_data_q;
  logic [16:0] ld_base_q;
  logic f_wr_ready, f_rd_valid;
  logic [FW-1:0] f_rd_data;
  wire [16:0] ld_start = (ld_idx_q == '0) ? page_base : ld_base_q;
  wire [16:0] ld_addr = ld_start + 17'(ld_idx_q);
  wire pw_take = !PAGE_WR_VALID_OUT || PAGE_WR_READY_IN;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hold_q <= 1'b0;
      hold_data_q <= '0;
      ld_base_q <= '0;
    end else begin
      if (ld_ev) begin
        hold_q <= 1'b1;
        hold_data_q <= {ld_addr, ld_byte_q};
        if (ld_idx_q == '0) ld_base_q <= page_base;
      end else if (f_wr_ready) begin
        hold_q <= 1'b0;
      end
    end
  end

  byte_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .wr_valid_in(hold_q),
    .wr_ready_out(f_wr_ready),
    .wr_data_in(hold_data_q),
    .rd_valid_out(f_rd_valid),
    .rd_ready_in(pw_take),
    .rd_data_out(f_rd_data)
  );

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PAGE_WR_VALID_OUT <= 1'b0;
      PAGE_WR_ADDR_OUT <= '0;
      PAGE_WR_DATA_OUT <= '0;
    end else if (pw_take) begin
      PAGE_WR_VALID_OUT <= f_rd_valid;
      PAGE_WR_ADDR_OUT <= f_rd_data[FW-1:8];
      PAGE_WR_DATA_OUT <= f_rd_data[7:0];
    end
  end

  // ********************************
  // page read fetch
  // ********************************
  logic [16:0] rd_base_q;
  wire [16:0] rd_start = (rd_idx_q == '0) ? page_base : rd_base_q;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      FLASH_RD_REQ_OUT <= 1'b0;
      FLASH_RD_ADDR_OUT <= '0;
      rd_base_q <= '0;
      rd_data_q <= '0;
      ack_tgl_q <= 1'b0;
    end else if (rd_ev) begin
      FLASH_RD_REQ_OUT <= 1'b1;
      FLASH_RD_ADDR_OUT <= rd_start + 17'(rd_idx_q);
      if (rd_idx_q == '0) rd_base_q <= page_base;
    end else if (FLASH_RD_REQ_OUT && FLASH_RD_VALID_IN) begin
      FLASH_RD_REQ_OUT <= 1'b0;
      rd_data_q <= FLASH_RD_DATA_IN;
      ack_tgl_q <= rd_s3_q;
    end
  end
endmodule
`default_nettype wire

// ==== tb/page_access_props.sv ====
// checker for the page access port, bound to its top ports
// assumes the page buffer and flash read handshakes run on CLK_IN
`default_nettype none
module page_access_props #(
  parameter int PAGE_BYTES = 128,
  parameter int PROGRAM_COUNTER_TOP_BIT = 13
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic PROG_MODE_OUT,
  input wire logic PAGE_WR_VALID_OUT,
  input wire logic [16:0] PAGE_WR_ADDR_OUT,
  input wire logic [7:0] PAGE_WR_DATA_OUT,
  input wire logic PAGE_WR_READY_IN,
  input wire logic FLASH_RD_REQ_OUT,
  input wire logic [16:0] FLASH_RD_ADDR_OUT,
  input wire logic FLASH_RD_VALID_IN
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // ****
  // last byte address taken by the page buffer
  // ****
  logic [16:0] last_q;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN)
      last_q <= '0;
    else if (PAGE_WR_VALID_OUT && PAGE_WR_READY_IN)
      last_q <= PAGE_WR_ADDR_OUT;
  end
  sequence wr_stall_s; PAGE_WR_VALID_OUT && !PAGE_WR_READY_IN; endsequence
  sequence wr_take_s; PAGE_WR_VALID_OUT && PAGE_WR_READY_IN; endsequence
  sequence rd_wait_s; FLASH_RD_REQ_OUT && !FLASH_RD_VALID_IN; endsequence
  wr_hold_a: assert property (wr_stall_s |=> PAGE_WR_VALID_OUT && $stable(PAGE_WR_DATA_OUT)
    && $stable(PAGE_WR_ADDR_OUT)) else $error("page write dropped while stalled");
  wr_step_a: assert property (wr_take_s ##0 (PAGE_WR_ADDR_OUT % PAGE_BYTES != 0)
    |-> PAGE_WR_ADDR_OUT == last_q + 17'h1) else $error("page write address not consecutive");
  wr_range_a: assert property (PAGE_WR_VALID_OUT |-> (PAGE_WR_ADDR_OUT >> (PROGRAM_COUNTER_TOP_BIT + 2)) == 0)
    else $error("page write address above top bit");
  rd_range_a: assert property (FLASH_RD_REQ_OUT |-> (FLASH_RD_ADDR_OUT >> (PROGRAM_COUNTER_TOP_BIT + 2)) == 0)
    else $error("flash read address above top bit");
  rd_hold_a: assert property (rd_wait_s |=> FLASH_RD_REQ_OUT && $stable(FLASH_RD_ADDR_OUT))
    else $error("flash read request dropped early");
  rd_drop_a: assert property (FLASH_RD_REQ_OUT && FLASH_RD_VALID_IN |=> !FLASH_RD_REQ_OUT)
    else $error("flash read request held after answer");
  rd_gate_a: assert property ($rose(FLASH_RD_REQ_OUT) |-> PROG_MODE_OUT)
    else $error("flash read outside programming mode");
  wr_gate_a: assert property ($rose(PAGE_WR_VALID_OUT) |-> PROG_MODE_OUT)
    else $error("page write outside programming mode");
endmodule
bind page_access_port page_access_props #(
  .PAGE_BYTES(PAGE_BYTES),
  .PROGRAM_COUNTER_TOP_BIT(PROGRAM_COUNTER_TOP_BIT)
) page_access_props_inst (
  .CLK_IN(CLK_IN),
  .RST_IN(RST_IN),
  .PROG_MODE_OUT(PROG_MODE_OUT),
  .PAGE_WR_VALID_OUT(PAGE_WR_VALID_OUT),
  .PAGE_WR_ADDR_OUT(PAGE_WR_ADDR_OUT),
  .PAGE_WR_DATA_OUT(PAGE_WR_DATA_OUT),
  .PAGE_WR_READY_IN(PAGE_WR_READY_IN),
  .FLASH_RD_REQ_OUT(FLASH_RD_REQ_OUT),
  .FLASH_RD_ADDR_OUT(FLASH_RD_ADDR_OUT),
  .FLASH_RD_VALID_IN(FLASH_RD_VALID_IN)
);
`default_nettype wire

// ==== tb/tap_programmer.sv ====
// boundary-scan programmer model driving the test port
// assumes tdo is launched on the falling test clock edge
`default_nettype none
module tap_programmer (
  output logic TCK_OUT,
  output logic TMS_OUT,
  output logic TDI_OUT,
  input wire logic TDO_IN
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // one 30 ns test clock period; clock stands low between frames
  // ****
  initial begin
    TCK_OUT = 1'b0;
    TMS_OUT = 1'b1;
    TDI_OUT = 1'b0;
  end
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    TMS_OUT = tms;
    TDI_OUT = tdi;
    #15;
    tdo = TDO_IN;
    TCK_OUT = 1'b1;
    #15;
    TCK_OUT = 1'b0;
  endtask
  task automatic go_idle(input int n);
    logic d;
    repeat (n) tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
  endtask
  task automatic shift(input logic ir, input logic [1039:0] din, input int n, output logic [1039:0] dout);
    logic d;
    dout = '0;
    tick(1'b1, 1'b0, d);
    if (ir)
      tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
    tick(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++)
      tick(i == n - 1, din[i], dout[i]);
    // released data line shows the inverse, not a held value
    tick(1'b1, ~din[n-1], d);
    tick(1'b0, ~din[n-1], d);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the page access port
// assumes the programmer model drives the test port and the bench models flash and page buffer
`default_nettype none
module tb import page_access_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, rst_in, tck, tms, tdi, tdo, tdo_oe, core_rst, prog_mode;
  logic wr_valid, wr_ready, rd_req, rd_valid, ready_en;
  logic [16:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data;
  logic [1:0] ph_q, rw_q;
  logic [1039:0] din, dout;
  logic [16:0] got_addr[$];
  logic [7:0] got_data[$];
  int fail_count, num_checks;
  page_access_port page_access_port_inst (.CLK_IN(clk_in), .RST_IN(rst_in), .TCK_IN(tck), .TMS_IN(tms),
    .TDI_IN(tdi), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe), .CORE_RESET_OUT(core_rst), .PROG_MODE_OUT(prog_mode),
    .PAGE_WR_VALID_OUT(wr_valid), .PAGE_WR_ADDR_OUT(wr_addr), .PAGE_WR_DATA_OUT(wr_data),
    .PAGE_WR_READY_IN(wr_ready), .FLASH_RD_REQ_OUT(rd_req), .FLASH_RD_ADDR_OUT(rd_addr),
    .FLASH_RD_DATA_IN(rd_data), .FLASH_RD_VALID_IN(rd_valid));
  tap_programmer tap_programmer_inst (.TCK_OUT(tck), .TMS_OUT(tms), .TDI_OUT(tdi), .TDO_IN(tdo));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // ****
  // page buffer sink and flash responder
  // ****
  initial begin
    {wr_ready, rd_valid, ready_en, ph_q, rw_q, rd_data} = '0;
    rst_in = 1'b1;
  end
  always @(posedge clk_in) begin
    ph_q <= ph_q + 2'h1;
    // half-rate ready keeps the sink slower than the fifo drain
    wr_ready <= ready_en && ph_q[0];
    if (wr_valid && wr_ready) begin
      got_addr.push_back(wr_addr);
      got_data.push_back(wr_data);
    end
    if (rd_req && !rd_valid) begin
      rw_q <= rw_q + 2'h1;
      if (rw_q == 2'h1) begin
        rd_valid <= 1'b1;
        rd_data <= rd_addr[7:0] ^ rd_addr[15:8] ^ 8'ha5;
      end
    end else begin
      rw_q <= 2'h0;
      rd_valid <= 1'b0;
      rd_data <= ~rd_data;
    end
  end
  // ****
  // shared tasks
  // ****
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic dr(input logic [3:0] code, input int n);
    tap_programmer_inst.shift(1'b1, 1040'(code), 4, dout);
    tap_programmer_inst.shift(1'b0, din, n, dout);
  endtask
  task automatic cmd(input logic [6:0] op, input logic [7:0] arg);
    din = 1040'({op, arg});
    dr(PROGRAMMING_COMMAND_INSTRUCTION, 15);
  endtask
  // ****
  // scenarios
  // ****
  task automatic enter_mode;
    din = 1040'h1;
    dr(CORE_RESET_INSTRUCTION, 1);
    din = 1040'(PROG_KEY ^ 16'h0001);
    dr(PROGRAMMING_ENABLE_INSTRUCTION, 16);
    repeat (10) @(posedge clk_in);
    check("core reset held", core_rst, 17'h1);
    check("mode after near key", prog_mode, 17'h0);
    din = 1040'(PROG_KEY);
    dr(PROGRAMMING_ENABLE_INSTRUCTION, 16);
    repeat (10) @(posedge clk_in);
    check("mode after key", prog_mode, 17'h1);
  endtask
  task automatic page_load;
    cmd(OP_MODE, 8'h10);
    cmd(OP_ADDR_HIGH, 8'hff);
    cmd(OP_ADDR_LOW, 8'h80);
    for (int i = 0; i < 128; i++)
      din[8*i +: 8] = 8'(i) ^ 8'h5a;
    fork
      dr(PAGE_LOAD_INSTRUCTION, 1024);
      begin
        for (int i = 0; i < 3000 && wr_valid !== 1'b1; i++) @(posedge clk_in);
        check("first page write", wr_valid, 17'h1);
        check("oe while shifting", tdo_oe, 17'h1);
        // stall long enough to nearly fill the fifo, then drain
        repeat (360) @(posedge clk_in);
        ready_en <= 1'b1;
      end
    join
    for (int i = 0; i < 600 && got_addr.size() < 128; i++) @(posedge clk_in);
    check("oe after shift", tdo_oe, 17'h0);
    check("bytes written", 17'(got_addr.size()), 17'd128);
    for (int i = 0; i < 128 && i < got_addr.size(); i++) begin
      check("write address", got_addr[i], 17'h7f00 + 17'(i));
      check("write data", 17'(got_data[i]), 17'(8'(i) ^ 8'h5a));
    end
  endtask
  task automatic page_read;
    // eeprom mask: high byte ff keeps only address bits up to the eeprom top bit
    cmd(OP_MODE, 8'h03);
    cmd(OP_ADDR_HIGH, 8'hff);
    cmd(OP_ADDR_LOW, 8'h40);
    din = '0;
    dr(PAGE_READ_INSTRUCTION, 1032);
    for (int i = 0; i < 128; i++)
      check("read byte", 17'(dout[8+8*i +: 8]), 17'((8'h80 + 8'(i)) ^ 8'h06 ^ 8'ha5));
  endtask
  task automatic leave_mode;
    int n;
    cmd(OP_MODE, MODE_NOOP);
    cmd(7'h33, 8'h00);
    din = '0;
    dr(PROGRAMMING_ENABLE_INSTRUCTION, 16);
    repeat (10) @(posedge clk_in);
    check("mode after zero", prog_mode, 17'h0);
    n = got_addr.size();
    din = 1040'hff;
    dr(PAGE_LOAD_INSTRUCTION, 16);
    repeat (40) @(posedge clk_in);
    check("refused load", 17'(got_addr.size()), 17'(n));
    din = '0;
    dr(CORE_RESET_INSTRUCTION, 1);
    repeat (10) @(posedge clk_in);
    check("core released", core_rst, 17'h0);
  endtask
  initial begin
    #400us;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    fork
      #7 tap_programmer_inst.go_idle(2);
    join_none
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    #13;
    tap_programmer_inst.go_idle(5);
    enter_mode();
    page_load();
    page_read();
    leave_mode();
    tally_and_finish();
  end
endmodule
`default_nettype wire
